//--- pioc_defines.vh
// pioc_defines.vh: register map, field layout and reset values for
// the parallel i/o pin control block.
// assumes a 32-bit classic wishbone slave with byte addresses.
`ifndef PIOC_DEFINES_VH
`define PIOC_DEFINES_VH

// port slot: byte address bits [6:5] pick the port
`define PIOC_PORT_A        2'h0
`define PIOC_PORT_B        2'h1
`define PIOC_PORT_C        2'h2
// register slot inside a port: byte address bits [4:2]
`define PIOC_REG_DATA      3'h0
`define PIOC_REG_DIR       3'h1
`define PIOC_REG_PULLUP    3'h2
`define PIOC_REG_SLEW      3'h3
`define PIOC_REG_DRIVE     3'h4
// address field positions
`define PIOC_PORT_MSB      6
`define PIOC_PORT_LSB      5
`define PIOC_SLOT_MSB      4
`define PIOC_SLOT_LSB      2
`define PIOC_ADR_TOP_LSB   7

// implemented bits per port: a[5:0], b[7:0], c[3:0]
`define PIOC_MASK_A        8'h3F
`define PIOC_MASK_B        8'hFF
`define PIOC_MASK_C        8'h0F
// output-only pin: port a bit 4 (flat pin 4)
`define PIOC_OUT_ONLY      18'h00010

// reset values of all control registers
`define PIOC_RST_DATA      8'h00
`define PIOC_RST_DIR       8'h00
`define PIOC_RST_PULLUP    8'h00
`define PIOC_RST_SLEW      8'h00
`define PIOC_RST_DRIVE     8'h00

`endif

//--- pioc_pad_model.sv
// pad model: board lines around the pins
// assumes the bench picks an outside driver per pin
`timescale 1ns/1ps
module pioc_pad_model
(
   // pad side
   input  wire        clk,
   input  wire [17:0] pinOut,
   input  wire [17:0] pinOe,
   input  wire [17:0] pinPullup,
   input  wire [17:0] extEn,
   input  wire [17:0] extVal,
   output wire [17:0] pinIn
);
   // a floating line toggles so a read never matches by luck
   reg [17:0] tog_q = 18'h00000;
   always @(posedge clk)
      tog_q <= ~tog_q;
   // chip driver first, then board driver, then pull-up or float
   assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal)
                | (~pinOe & ~extEn & (pinPullup | tog_q));
endmodule

//--- pioc_pin_control.v
// pioc_pin_control.v: general-purpose pin control for three ports,
// with direction, data, pull-up, slew and drive registers on wishbone.
// assumes pad cells outside that act on the enables and selects here,
// and peripherals that present their own enable and output per pin.
//
// Function
// - three ports, seventeen two-way pins plus one output-only pin.
// - an enabled sharing peripheral takes the pin from gpio.
// - reset leaves shared functions off and every direction bit zero; here reset leaves the peripheral enables alone, an enabled peripheral keeps its pin.
// - reset clears slew limit, high drive and pull-up enables.
// - direction bit enables the driver and picks the data read source.
// - input buffer on unless analog owns pin or pin is output-only.
// - digital peripheral drives the pin; direction still picks read source.
// - analog ownership disables both input buffer and output driver.
// - input-direction read returns zero when the input buffer is off.
// - analog function wins over an alternate digital function.
// - pull, slew and drive registers independent of data and direction.
// - pull-up off whenever gpio or a peripheral drives the pin.
// - pull-up off whenever an analog function controls the pin.
// - per-pin slew limit bit limits output edge rate when set.
// - slew limit has no effect while the pin is an input.
// - per-pin high drive bit selects the strong driver.
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "pioc_defines.vh"

module pioc_pin_control
(
   // clock, reset, enable
   input  wire        clk,
   input  wire        nrst,
   input  wire        ce,
   // wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [31:0] wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // pins: {portC[3:0], portB[7:0], portA[5:0]}
   input  wire [17:0] pinIn,
   output wire [17:0] pinOut,
   output wire [17:0] pinOe,
   output wire [17:0] pinInEn,
   output wire [17:0] pinPullup,
   output wire [17:0] pinSlewLimit,
   output wire [17:0] pinHighDrive,
   // shared peripherals, one bit per pin
   input  wire [17:0] altEnable,
   input  wire [17:0] altOe,
   input  wire [17:0] altOut,
   input  wire [17:0] analogEnable
);

   // control registers held as 3 ports x 8 bits, unused bits stay 0
   reg  [23:0] dataQ;
   reg  [23:0] dirQ;
   reg  [23:0] pullupQ;
   reg  [23:0] slewQ;
   reg  [23:0] driveQ;
   reg  [17:0] syncAQ;
   reg  [17:0] syncBQ;
   reg  [23:0] dataD;
   reg  [23:0] dirD;
   reg  [23:0] pullupD;
   reg  [23:0] slewD;
   reg  [23:0] driveD;
   reg  [31:0] rdD;

   wire        busReq;
   wire        hit;
   wire [1:0]  portSel;
   wire [2:0]  slotSel;
   wire [7:0]  portMask;
   wire [4:0]  portBase;
   wire [7:0]  wrByte;
   wire [17:0] dataN;
   wire [17:0] dirN;
   wire [17:0] pullupN;
   wire [17:0] slewN;
   wire [17:0] driveN;
   wire [17:0] analogOwn;
   wire [17:0] altOwn;
   wire [17:0] readN;
   wire [23:0] readW;

   // wide to flat pin mapping
   assign dataN   = {dataQ[19:16], dataQ[15:8], dataQ[5:0]};
   assign dirN    = {dirQ[19:16], dirQ[15:8], dirQ[5:0]};
   assign pullupN = {pullupQ[19:16], pullupQ[15:8], pullupQ[5:0]};
   assign slewN   = {slewQ[19:16], slewQ[15:8], slewQ[5:0]};
   assign driveN  = {driveQ[19:16], driveQ[15:8], driveQ[5:0]};

   // ownership: analog over digital peripheral over gpio
   // analog priority
   assign analogOwn = analogEnable;
   assign altOwn    = altEnable & ~analogEnable;

   // output driver and value
   // analog kills driver
   assign pinOe  = ~analogOwn & ((altOwn & altOe) | (~altOwn & dirN));
   assign pinOut = (altOwn & altOut) | (~altOwn & dataN);

   // input buffer stays on except analog or output-only pins
   // input buffer rule
   // output-only pin has no input path
   assign pinInEn = ~analogOwn & ~`PIOC_OUT_ONLY;

   // pull-up dropped while driven or analog, whatever the enable says
   // pull-up off when driven
   assign pinPullup = pullupN & ~pinOe & ~analogOwn;

   // slew limit only matters on a driven pin
   // per-pin slew limit
   assign pinSlewLimit = slewN & pinOe;
   assign pinHighDrive = driveN;

   // two-flop pin synchroniser; first stage feeds only the second
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         syncAQ <= 18'h00000;
         syncBQ <= 18'h00000;
      end
      else if (ce)
      begin
         syncAQ <= pinIn;
         syncBQ <= syncAQ;
      end
   end

   // data read source per pin, direction decides even under peripherals
   // latch or synced level
   assign readN = (dirN & dataN) | (~dirN & pinInEn & syncBQ);
   assign readW = {4'h0, readN[17:14], readN[13:6], 2'h0, readN[5:0]};

   // bus decode
   assign busReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign portSel = wb_adr_i[`PIOC_PORT_MSB:`PIOC_PORT_LSB];
   assign slotSel = wb_adr_i[`PIOC_SLOT_MSB:`PIOC_SLOT_LSB];
   assign hit     = (wb_adr_i[31:`PIOC_ADR_TOP_LSB] == 25'h0000000)
                  & (wb_adr_i[1:0] == 2'h0)
                  & (portSel != 2'h3)
                  & (slotSel <= `PIOC_REG_DRIVE);
   assign portMask = (portSel == `PIOC_PORT_A) ? `PIOC_MASK_A :
                     (portSel == `PIOC_PORT_B) ? `PIOC_MASK_B :
                     (portSel == `PIOC_PORT_C) ? `PIOC_MASK_C : 8'h00;
   assign portBase = (portSel == `PIOC_PORT_B) ? 5'h08 :
                     (portSel == `PIOC_PORT_C) ? 5'h10 : 5'h00;
   // unimplemented pins never store a one
   assign wrByte   = wb_dat_i[7:0] & portMask;

   // register next values; each register only changes by its own write
   // independent registers
   always @*
   begin
      dataD   = dataQ;
      dirD    = dirQ;
      pullupD = pullupQ;
      slewD   = slewQ;
      driveD  = driveQ;
      rdD     = 32'h00000000;
      if (busReq && hit)
      begin
         if (slotSel == `PIOC_REG_DATA)
         begin
            rdD[7:0] = readW[portBase +: 8];
            if (wb_we_i && wb_sel_i[0])
               dataD[portBase +: 8] = wrByte;
         end
         else if (slotSel == `PIOC_REG_DIR)
         begin
            rdD[7:0] = dirQ[portBase +: 8];
            if (wb_we_i && wb_sel_i[0])
               dirD[portBase +: 8] = wrByte;
         end
         else if (slotSel == `PIOC_REG_PULLUP)
         begin
            rdD[7:0] = pullupQ[portBase +: 8];
            if (wb_we_i && wb_sel_i[0])
               pullupD[portBase +: 8] = wrByte;
         end
         else if (slotSel == `PIOC_REG_SLEW)
         begin
            rdD[7:0] = slewQ[portBase +: 8];
            if (wb_we_i && wb_sel_i[0])
               slewD[portBase +: 8] = wrByte;
         end
         else
         begin
            rdD[7:0] = driveQ[portBase +: 8];
            if (wb_we_i && wb_sel_i[0])
               driveD[portBase +: 8] = wrByte;
         end
      end
   end

   // register file and bus answer, one wait state, ack for one cycle
   // directions cleared at reset
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         dataQ    <= {3{`PIOC_RST_DATA}};
         dirQ     <= {3{`PIOC_RST_DIR}};
         pullupQ  <= {3{`PIOC_RST_PULLUP}};
         slewQ    <= {3{`PIOC_RST_SLEW}};
         driveQ   <= {3{`PIOC_RST_DRIVE}};
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else if (ce)
      begin
         dataQ    <= dataD;
         dirQ     <= dirD;
         pullupQ  <= pullupD;
         slewQ    <= slewD;
         driveQ   <= driveD;
         wb_ack_o <= busReq;    // unmapped addresses ack too, read zero
         wb_dat_o <= rdD;
      end
   end

endmodule

//--- pioc_pin_control_chk.sv
// checker: pin ownership and reset state of the pad controls
// assumes a bind onto pioc_pin_control, ports only
`timescale 1ns/1ps
module pioc_pin_control_chk
(
   // clock and bus
   input wire        clk,
   input wire        nrst,
   input wire        wb_we_i,
   input wire        wb_ack_o,
   // pads and owners
   input wire [17:0] pinOe,
   input wire [17:0] pinInEn,
   input wire [17:0] pinPullup,
   input wire [17:0] pinSlewLimit,
   input wire [17:0] altEnable,
   input wire [17:0] altOe,
   input wire [17:0] analogEnable
);
   // pins held by a digital peripheral, analog not claiming them
   wire [17:0] dig = altEnable & ~analogEnable;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // reset release checks must not be masked by the reset itself
   property rst_dir_p;
      disable iff (1'b0) $rose(nrst) |-> pinOe == (altOe & dig);
   endproperty
   property rst_pad_p;
      disable iff (1'b0)
      $rose(nrst) |-> ##1 (pinPullup | pinSlewLimit) == 18'h00000;
   endproperty
   an_drv_a: assert property ((pinOe & analogEnable) == 18'h00000)
      else $error("driver on under analog");
   in_buf_a: assert property (pinInEn == (~analogEnable & 18'h3FFEF))
      else $error("input buffer enable wrong");
   alt_own_a: assert property ((pinOe & dig) == (altOe & dig))
      else $error("peripheral not driving its pin");
   pu_out_a: assert property ((pinPullup & pinOe) == 18'h00000)
      else $error("pull-up on a driven pin");
   pu_an_a: assert property ((pinPullup & analogEnable) == 18'h00000)
      else $error("pull-up on an analog pin");
   slew_in_a: assert property ((pinSlewLimit & ~pinOe) == 18'h00000)
      else $error("slew limit on an input");
   // no gpio drive after reset; checked across the release itself
   rst_dir_a: assert property (rst_dir_p)
      else $error("gpio driver on after reset");
   rst_pad_a: assert property (rst_pad_p)
      else $error("pad controls not cleared");
   // main scenarios
   cover property (wb_ack_o && wb_we_i);
   cover property (wb_ack_o && !wb_we_i);
   cover property ((altEnable & analogEnable) != 18'h00000);
endmodule

//--- pioc_pin_control_tb.sv
// bench: register rows, then ownership, input path and reset cases
// assumes pioc_pin_control, its checker and the pad model
`timescale 1ns/1ps
module pioc_pin_control_tb;
   reg         clk = 1'b0;
   reg         nrst = 1'b0;
   reg         cyc = 1'b0;
   reg         ce = 1'b1;
   reg         we = 1'b0;
   reg  [31:0] adr = 32'h00000000;
   reg  [31:0] wdat = 32'h00000000;
   reg  [31:0] r;
   reg  [17:0] altEnable = 18'h00000;
   reg  [17:0] altOe = 18'h00000;
   reg  [17:0] altOut = 18'h00000;
   reg  [17:0] analogEnable = 18'h00000;
   reg  [17:0] extEn = 18'h00000;
   reg  [17:0] extVal = 18'h00000;
   wire [31:0] rdat;
   wire        ack;
   wire [17:0] pinIn, pinOut, pinOe, pinInEn, pinPullup;
   wire [17:0] pinSlewLimit, pinHighDrive;
   integer     check_count = 0;
   integer     n_mismatch = 0;
   integer     i;
   // rows: address, write byte, byte read back
   localparam [23:0] ROWS [6] = '{24'h04FF3F, 24'h48FF0F, 24'h2CAAAA,
      24'h305555, 24'h14FF00, 24'h60FF00};
   pioc_pin_control u_pioc_pin_control (.clk, .nrst, .ce(ce),
      .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .pinIn, .pinOut, .pinOe, .pinInEn, .pinPullup, .pinSlewLimit,
      .pinHighDrive, .altEnable, .altOe, .altOut, .analogEnable);
   pioc_pad_model u_pioc_pad_model (.clk, .pinOut, .pinOe, .pinPullup,
      .extEn, .extVal, .pinIn);
   initial
      forever #2 clk = ~clk;
   task chk(input [31:0] got, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp)
         begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // one classic cycle; request held until ack is sampled high at an
   // edge, read data taken at that same edge; only the watchdog ends it
   task bus(input w, input [31:0] a, input [31:0] d);
      begin
         @(posedge clk);
         cyc <= 1'b1;
         we <= w;
         adr <= a;
         wdat <= d;
         @(posedge clk);
         while (ack !== 1'b1)
            @(posedge clk);
         r = rdat;
         cyc <= 1'b0;
         we <= 1'b0;
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", check_count, n_mismatch);
         if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   initial
   begin
      #20000;
      n_mismatch = n_mismatch + 1;
      final_report;
   end
   initial
   begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      bus(1'b1, 32'h00, 32'h2A);
      for (i = 0; i < 6; i = i + 1)
      begin
         bus(1'b1, {24'h0, ROWS[i][23:16]}, {24'h0, ROWS[i][15:8]});
         bus(1'b0, {24'h0, ROWS[i][23:16]}, 32'h0);
         chk(r, {24'h0, ROWS[i][7:0]});
      end
      @(negedge clk);
      chk(pinHighDrive, 18'h01540);
      chk(pinPullup, 18'h3C000);
      chk(pinSlewLimit, 18'h00000);
      chk(pinOe, 18'h0003F);
      chk(pinOut & 18'h0003F, 18'h0002A);
      // shared owners plus a board driver on port b
      @(posedge clk);
      extEn <= 18'h03FC0;
      extVal <= 18'h02940;
      altEnable <= 18'h000C1;
      altOe <= 18'h00080;
      altOut <= 18'h00080;
      analogEnable <= 18'h00040;
      // pin levels need two edges through the synchroniser
      repeat (2) @(posedge clk);
      bus(1'b0, 32'h20, 32'h0);
      chk(r, 32'hA6);
      bus(1'b0, 32'h00, 32'h0);
      chk(r, 32'h2A);
      @(negedge clk);
      chk(pinOe, 18'h000BE);
      chk(pinOut & 18'h00080, 18'h00080);
      chk(pinSlewLimit, 18'h00080);
      chk(pinInEn, 18'h3FFAF);
      // second reset in mid-run
      @(posedge clk);
      nrst <= 1'b0;
      @(negedge clk);
      chk(pinOe, 18'h00080);
      chk(pinHighDrive | pinPullup, 18'h00000);
      @(posedge clk);
      nrst <= 1'b1;
      bus(1'b0, 32'h04, 32'h0);
      chk(r, 32'h00);
      // clock enable low: request must wait, no write lands
      @(posedge clk);
      ce <= 1'b0;
      cyc <= 1'b1;
      we <= 1'b1;
      adr <= 32'h04;
      wdat <= 32'h02;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(ack, 1'b0);
      chk(pinOe, 18'h00080);
      @(posedge clk);
      ce <= 1'b1;
      @(posedge clk);
      while (ack !== 1'b1)
         @(posedge clk);
      cyc <= 1'b0;
      we <= 1'b0;
      @(negedge clk);
      chk(pinOe, 18'h00082);
      final_report;
   end
endmodule
bind pioc_pin_control pioc_pin_control_chk u_pioc_pin_control_chk (.clk,
   .nrst, .wb_we_i, .wb_ack_o, .pinOe, .pinInEn, .pinPullup,
   .pinSlewLimit, .altEnable, .altOe, .analogEnable);
